// File: logic/hbc_host_port.sv
`timescale 1ns/1ps
module hbc_host_port #(
  parameter int unsigned NSRC = hbc_pkg::NUM_SRC
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic chip_en_n_i,          // Active-low chip enable
  input wire logic data_strobe_n_i,      // Data strobe
  input wire logic rd_wr_i,              // 1 read, 0 write (with strobe)
  input wire logic rd_n_i,               // Separate read strobe
  input wire logic wr_n_i,               // Separate write strobe
  input wire logic addr_strobe_n_i,      // Address strobe
  input wire logic section_select_pin_i, // Low selects serial section
  input wire logic channel_select_pin_i, // Channel select
  input wire logic irq_ack_in_n_i,       // Acknowledge input
  input wire logic prio_chain_in_i,      // Priority chain input
  input wire logic [15:0] ad_i,          // Address/data bus in
  input wire logic bus_master_i,         // DMA section owns the bus
  input wire logic master_rd_i,          // Master reading memory
  input wire logic master_strobe_i,      // Master strobe active
  input wire logic dma_addr_lsb_i,       // DMA address bit 0
  input wire logic [7:0] dev_byte_i,     // Byte from device core
  input wire logic [NSRC-1:0] src_req_i, // Internal sources pending
  input wire logic [NSRC-1:0] src_en_i,  // Per-source enables
  input wire logic [NSRC-1:0] src_is_dma_i, // Source in DMA section
  input wire logic [7:0] master_irq_ctrl_i, // Serial section control
  input wire logic [7:0] dma_irq_ctrl_i,    // DMA section control
  input wire logic [7:0] vector_base_i,     // Vector base
  input wire logic status_in_vec_i,         // Include source status
  input wire logic wait_rdy_i,              // Handshake pin in
  output logic wait_rdy_o,                  // Handshake pin out
  output logic wait_rdy_oe_n_o,             // Low while driving
  output logic [15:0] ad_o,                 // Address/data out
  output logic ad_oe_n_o,                   // Low while driving bus
  output logic irq_n_o,                     // Interrupt request
  output logic [7:0] bus_config_word_o,     // Captured word
  output logic cfg_done_o,                  // Configuration taken
  output logic mux_mode_o,                  // Multiplexed mode
  output logic wait_style_o,                // 1 wait, 0 ready
  output logic [4:0] reg_addr_o,            // Decoded register index
  output logic [7:0] wr_byte_o,             // Slave write byte
  output logic wr_stb_o,                    // Slave write pulse
  output logic [7:0] dma_byte_o,            // Master read byte
  output logic dma_byte_vld_o,              // Master read pulse
  output logic master_go_o                  // Master may proceed
);
  localparam int unsigned SW = $clog2(NSRC);

  // Slave strobes, either style, gated by chip enable
  logic rd_act, wr_act, acc_act;
  assign rd_act = !chip_en_n_i && ((!data_strobe_n_i && rd_wr_i) ||
                  !rd_n_i);
  assign wr_act = !chip_en_n_i && ((!data_strobe_n_i && !rd_wr_i) ||
                  !wr_n_i);
  assign acc_act = rd_act || wr_act;

  logic acc_q;            // Strobe active last cycle
  logic as_q;             // Address strobe active last cycle
  logic as_seen_q;        // Address strobe seen before configuration
  logic [4:0] addr_lat_q; // Latched multiplexed address
  logic ack_lat_q;        // Latched status acknowledge
  logic cfg_done_q;
  logic [7:0] cfg_q;
  logic mux_q, wait_q;
  logic acc_edge;
  assign acc_edge = acc_act && !acc_q;

  // Edge tracking of strobes
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= 1'b0;
      as_q <= 1'b0;
    end else begin
      acc_q <= acc_act;
      as_q <= !addr_strobe_n_i;
    end
  end

  // Address strobe history decides bus mode at configuration
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      as_seen_q <= 1'b0;
      addr_lat_q <= 5'h00;
    end else begin
      if (!addr_strobe_n_i && !bus_master_i) begin
        as_seen_q <= 1'b1;
        // Left shift uses lines 5..1, right shift 4..0
        addr_lat_q <= cfg_q[hbc_pkg::CFG_SHIFT_BIT] ? ad_i[4:0]
                                                    : ad_i[5:1];
      end
    end
  end

  // One-time configuration capture; reset re-arms it
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_done_q <= 1'b0;
      cfg_q <= hbc_pkg::CFG_RESET;
      mux_q <= 1'b0;
      wait_q <= 1'b0;
    end else if (!cfg_done_q && wr_act && acc_edge &&
                 !section_select_pin_i) begin
      // Later writes never reach here again
      cfg_done_q <= 1'b1;
      cfg_q <= ad_i[7:0];
      mux_q <= as_seen_q;
      wait_q <= channel_select_pin_i;
    end
  end

  // Settings act in the config cycle itself, bypassing the latch
  logic mux_eff, wait_eff;
  assign mux_eff = cfg_done_q ? mux_q : as_seen_q;
  assign wait_eff = cfg_done_q ? wait_q : channel_select_pin_i;

  logic [1:0] ack_style;
  assign ack_style =
      cfg_q[hbc_pkg::CFG_ACK_HI_BIT:hbc_pkg::CFG_ACK_LO_BIT];

  // Status acknowledge latched per bus mode
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_lat_q <= 1'b0;
    end else if (mux_eff) begin
      if (as_q && addr_strobe_n_i) begin
        ack_lat_q <= !irq_ack_in_n_i;
      end
    end else if (acc_edge) begin
      ack_lat_q <= !irq_ack_in_n_i;
    end
  end

  // Priority encode: lowest index wins
  logic [NSRC-1:0] live;
  logic any_live;
  logic [SW-1:0] win;
  assign live = src_req_i & src_en_i;
  assign any_live = |live;
  always_comb begin
    win = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (live[i]) begin
        win = SW'(i);
      end
    end
  end

  // Acknowledge strobe qualifier per style
  logic ack_cyc, vec_stb, novec, vec_drive;
  // Non-multiplexed status: the latch lags its own strobe edge by a
  // cycle, so the pin is used at that edge; no read data leaks out
  logic ack_now;
  assign ack_now = (!mux_eff && acc_edge) ? !irq_ack_in_n_i : ack_lat_q;
  assign ack_cyc = (ack_style == hbc_pkg::ACK_STATUS) ? ack_now
                   : !irq_ack_in_n_i;
  assign vec_stb = (ack_style == hbc_pkg::ACK_STATUS) ? rd_act
                   : !irq_ack_in_n_i;
  // No-vector per section of the winning source
  assign novec = src_is_dma_i[win]
                 ? dma_irq_ctrl_i[hbc_pkg::DMA_NOVEC_BIT]
                 : master_irq_ctrl_i[hbc_pkg::MASTER_NOVEC_BIT];
  // Only highest pending responds, chain input high
  assign vec_drive = ack_cyc && vec_stb && prio_chain_in_i &&
                     any_live && !novec && !bus_master_i;

  logic [7:0] vec_val;
  always_comb begin
    vec_val = vector_base_i;
    if (status_in_vec_i) begin
      vec_val[SW-1:0] = win;
    end
  end

  // Lane steering for master reads
  hbc_lane_if lane ();
  assign lane.bus_data = ad_i;
  assign lane.addr_lsb = dma_addr_lsb_i;
  assign lane.swap_en = cfg_q[hbc_pkg::CFG_SWAP_EN_BIT];
  assign lane.swap_sel = cfg_q[hbc_pkg::CFG_SWAP_SEL_BIT];
  assign lane.mem_to_dev = bus_master_i && master_rd_i;
  hbc_lane_steer u_steer (
    .lane(lane)
  );

  // Handshake input sense: wait active high stalls, ready completes
  logic hs_ok;
  assign hs_ok = wait_eff ? !wait_rdy_i : wait_rdy_i;

  // Data bus drive: replicate byte on both lanes
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ad_o <= 16'h0000;
      ad_oe_n_o <= 1'b1;
    end else if (bus_master_i) begin
      ad_o <= {dev_byte_i, dev_byte_i};
      ad_oe_n_o <= !(master_strobe_i && !master_rd_i);
    end else if (vec_drive) begin
      ad_o <= {vec_val, vec_val};
      ad_oe_n_o <= 1'b0;
    end else begin
      ad_o <= {dev_byte_i, dev_byte_i};
      ad_oe_n_o <= !(rd_act && !ack_cyc);
    end
  end

  // Handshake pin: output as slave, input as master
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_rdy_o <= 1'b0;
      wait_rdy_oe_n_o <= 1'b1;
    end else if (bus_master_i) begin
      wait_rdy_o <= 1'b0;
      wait_rdy_oe_n_o <= 1'b1;
    end else begin
      // Completion one cycle after strobe edge for data or write; ready style marks a vector in the cycle it is driven
      wait_rdy_oe_n_o <= !(acc_act || ack_cyc);
      if (wait_eff) begin
        wait_rdy_o <= acc_edge;  // Wait asserted only first cycle
      end else begin
        wait_rdy_o <= (acc_act && !acc_edge) || vec_drive;
      end
    end
  end

  // Slave write path: low lane only
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_byte_o <= 8'h00;
      wr_stb_o <= 1'b0;
      reg_addr_o <= 5'h00;
    end else begin
      wr_byte_o <= ad_i[7:0];
      wr_stb_o <= wr_act && acc_edge && cfg_done_q && !bus_master_i;
      // Shift decode only in multiplexed mode
      reg_addr_o <= mux_eff ? addr_lat_q : 5'h00;
    end
  end

  // Master read data capture and go signal
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dma_byte_o <= 8'h00;
      dma_byte_vld_o <= 1'b0;
      master_go_o <= 1'b0;
    end else begin
      dma_byte_o <= lane.byte_out;
      dma_byte_vld_o <= lane.mem_to_dev && master_strobe_i && hs_ok;
      master_go_o <= bus_master_i && master_strobe_i && hs_ok;
    end
  end

  // Status outputs and single request
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_n_o <= 1'b1;
      bus_config_word_o <= hbc_pkg::CFG_RESET;
      cfg_done_o <= 1'b0;
      mux_mode_o <= 1'b0;
      wait_style_o <= 1'b0;
    end else begin
      irq_n_o <= !any_live;
      bus_config_word_o <= cfg_q;
      cfg_done_o <= cfg_done_q;
      mux_mode_o <= mux_eff;
      wait_style_o <= wait_eff;
    end
  end
endmodule

// File: shared/hbc_pkg.sv
package hbc_pkg;
  // Bus configuration word field positions
  localparam int unsigned CFG_SHIFT_BIT = 0;
  localparam int unsigned CFG_ACK_LO_BIT = 1;
  localparam int unsigned CFG_ACK_HI_BIT = 2;
  localparam int unsigned CFG_SWAP_SEL_BIT = 6;
  localparam int unsigned CFG_SWAP_EN_BIT = 7;
  // Value of the configuration word after reset (left shift decode)
  localparam logic [7:0] CFG_RESET = 8'h00;
  // No-vector bit positions in the two section control registers
  localparam int unsigned MASTER_NOVEC_BIT = 1;
  localparam int unsigned DMA_NOVEC_BIT = 5;
  // Acknowledge styles, coded as configuration bits 2:1
  localparam logic [1:0] ACK_STATUS = 2'h0;
  localparam logic [1:0] ACK_SINGLE = 2'h1;
  localparam logic [1:0] ACK_DOUBLE = 2'h3;
  // Number of internal interrupt sources
  localparam int unsigned NUM_SRC = 8;
  // Cycles from a slave request to the handshake marking completion
  localparam logic [1:0] SLAVE_LAT = 2'h1;
endpackage

// File: shared/hbc_lane_if.sv
`timescale 1ns/1ps
// Lane steering request and result between top and steering unit
interface hbc_lane_if;
  logic [15:0] bus_data;  // Raw 16-bit data bus
  logic addr_lsb;         // DMA address bit 0
  logic swap_en;          // Byte swap enable
  logic swap_sel;         // Byte swap select
  logic mem_to_dev;       // Master read from memory
  logic [7:0] byte_out;   // Selected byte
  modport top (output bus_data, addr_lsb, swap_en, swap_sel, mem_to_dev,
               input byte_out);
  modport unit (input bus_data, addr_lsb, swap_en, swap_sel, mem_to_dev,
                output byte_out);
endinterface

// File: logic/hbc_lane_steer.sv
`timescale 1ns/1ps
// Picks the incoming byte lane for reads from memory
module hbc_lane_steer (
  hbc_lane_if.unit lane
);
  // Lane choice is combinational; the top registers the result
  always_comb begin
    lane.byte_out = lane.bus_data[7:0];
    if (lane.mem_to_dev && lane.swap_en) begin
      // Select 1: even low, odd high; select 0: the reverse
      if (lane.swap_sel) begin
        lane.byte_out = lane.addr_lsb ? lane.bus_data[15:8]
                                      : lane.bus_data[7:0];
      end else begin
        lane.byte_out = lane.addr_lsb ? lane.bus_data[7:0]
                                      : lane.bus_data[15:8];
      end
    end
  end
endmodule

// File: sim/hbc_port_properties.sv
`timescale 1ns/1ps
// Pin-level checks of the host port; one clock domain
module hbc_port_props #(
  parameter int unsigned NSRC = 8
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic bus_master_i,
  input wire logic master_rd_i,
  input wire logic master_strobe_i,
  input wire logic dma_addr_lsb_i,
  input wire logic irq_ack_in_n_i,
  input wire logic channel_select_pin_i,
  input wire logic wait_rdy_i,
  input wire logic [15:0] ad_i,
  input wire logic [7:0] dev_byte_i,
  input wire logic [NSRC-1:0] src_req_i,
  input wire logic [NSRC-1:0] src_en_i,
  input wire logic [15:0] ad_o,
  input wire logic ad_oe_n_o,
  input wire logic irq_n_o,
  input wire logic [7:0] bus_config_word_o,
  input wire logic cfg_done_o,
  input wire logic wait_style_o,
  input wire logic wr_stb_o,
  input wire logic [7:0] dma_byte_o,
  input wire logic dma_byte_vld_o
);
  logic mrd; // Master read from memory, target ready
  logic hi_sel; // Swapped upper lane wanted
  logic hs_go; // Target handshake completes under the chosen style
  assign hs_go = wait_style_o ? !wait_rdy_i : wait_rdy_i;
  assign mrd = bus_master_i && master_rd_i && master_strobe_i && hs_go;
  assign hi_sel = bus_config_word_o[6] == dma_addr_lsb_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  lane_low_a: assert property (mrd && !bus_config_word_o[7]
    |=> dma_byte_vld_o && dma_byte_o == $past(ad_i[7:0]))
    else $error("dma byte not from low lane");
  lane_swap_a: assert property (mrd && bus_config_word_o[7]
    |=> dma_byte_vld_o && dma_byte_o == ($past(hi_sel) ?
    $past(ad_i[15:8]) : $past(ad_i[7:0])))
    else $error("dma byte on wrong lane");
  slave_no_dma_a: assert property (!bus_master_i |=> !dma_byte_vld_o)
    else $error("dma byte outside master read");
  master_wr_a: assert property (
    bus_master_i && master_strobe_i && !master_rd_i
    |=> ad_o == {2{$past(dev_byte_i)}})
    else $error("master write not on both lanes");
  slave_rd_a: assert property (
    !bus_master_i && !$past(bus_master_i) && !ad_oe_n_o
    && irq_ack_in_n_i && $past(irq_ack_in_n_i) |-> ad_o[15:8] == ad_o[7:0])
    else $error("slave read lanes differ");
  cfg_once_a: assert property (
    cfg_done_o |=> cfg_done_o && $stable(bus_config_word_o))
    else $error("config word changed after capture");
  style_samp_a: assert property (
    $rose(cfg_done_o) |-> wait_style_o == $past(channel_select_pin_i, 2))
    else $error("handshake style not sampled");
  no_early_wr_a: assert property (!cfg_done_o |=> !wr_stb_o)
    else $error("write strobe before config");
  irq_idle_a: assert property (!(|(src_req_i & src_en_i)) |=> irq_n_o)
    else $error("request without enabled source");
  cover property (mrd ##1 dma_byte_vld_o);
  cover property ($rose(cfg_done_o));
  cover property (!irq_n_o ##1 !ad_oe_n_o);
endmodule
bind hbc_host_port hbc_port_props #(.NSRC(NSRC)) u_props (
  .ref_clk_i, .arst_n_i, .bus_master_i, .master_rd_i, .master_strobe_i,
  .dma_addr_lsb_i, .irq_ack_in_n_i, .channel_select_pin_i, .wait_rdy_i,
  .ad_i,
  .dev_byte_i, .src_req_i, .src_en_i, .ad_o, .ad_oe_n_o, .irq_n_o,
  .bus_config_word_o, .cfg_done_o, .wait_style_o, .wr_stb_o, .dma_byte_o,
  .dma_byte_vld_o);

// File: sim/hbc_mem_model.sv
`timescale 1ns/1ps
// Memory answering the DMA section's reads
module hbc_mem_model #(
  parameter logic [15:0] WORD = 16'hc33c, // Stored word
  parameter int unsigned DLY = 1 // Slow-target delay
) (
  input wire logic ref_clk_i,
  input wire logic bus_master_i,
  input wire logic master_rd_i,
  input wire logic master_strobe_i,
  input wire logic wait_style_i,
  output logic [15:0] mem_ad_o,
  output logic wait_rdy_o
);
  logic [15:0] junk_q = 16'h5a5a; // Released bus pattern
  int unsigned age_q = 0; // Strobe age
  logic rd; // Read strobed
  logic stb; // Any strobed master cycle, read or write
  assign rd = bus_master_i && master_rd_i && master_strobe_i;
  assign stb = bus_master_i && master_strobe_i;
  // Word only under a read strobe; a late capture cannot match by luck
  assign mem_ad_o = rd ? WORD : junk_q;
  // Pattern flips every cycle
  always @(posedge ref_clk_i) begin
    junk_q <= ~junk_q;
    age_q <= stb ? age_q + 1 : 0;
  end
  // Slow target stretches reads and writes alike for DLY cycles
  assign wait_rdy_o = wait_style_i ? age_q < DLY : age_q >= DLY;
endmodule

// File: sim/tb_host_bus_config_and_handshake.sv
`timescale 1ns/1ps
// Config, slave, vector and DMA cycles through the host port
module tb_host_bus_config_and_handshake;
  localparam logic [15:0] MW = 16'hc33c; // Memory word
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic chip_en_n_i = 1'b1, data_strobe_n_i = 1'b1, rd_wr_i = 1'b1;
  logic rd_n_i = 1'b1, wr_n_i = 1'b1, addr_strobe_n_i = 1'b1;
  logic section_select_pin_i = 1'b0, channel_select_pin_i = 1'b0;
  logic irq_ack_in_n_i = 1'b1, prio_chain_in_i = 1'b1;
  logic bus_master_i = 1'b0, master_rd_i = 1'b0, master_strobe_i = 1'b0;
  logic dma_addr_lsb_i = 1'b0, status_in_vec_i = 1'b1, snap_oe;
  logic [15:0] host_ad = 16'h0000, snap;
  logic [7:0] dev_byte_i = 8'h96, src_req_i = 8'h00, src_en_i = 8'h00;
  logic [7:0] src_is_dma_i = 8'h00, master_irq_ctrl_i = 8'h00, exp;
  logic [7:0] dma_irq_ctrl_i = 8'h00, vector_base_i = 8'ha0;
  // Reserved bits 3..5 kept zero; each ack style once
  logic [7:0] cfgs [3] = '{8'h00, 8'hc2, 8'h86};
  wire logic [15:0] mem_ad, ad_i, ad_o;
  wire logic wait_rdy_i, ad_oe_n_o, irq_n_o, cfg_done_o, mux_mode_o;
  wire logic wait_style_o, wr_stb_o, dma_byte_vld_o;
  wire logic [7:0] bus_config_word_o, wr_byte_o, dma_byte_o;
  wire logic wait_rdy_o, wait_rdy_oe_n_o, master_go_o;
  wire logic [4:0] reg_addr_o;
  logic [1:0] snap_hs; // Handshake pin enable and level
  logic [7:0] wr_seen = 8'h00; // Byte paired with the last write pulse
  int fails = 0, n_checks = 0, k, j;
  int n_wr = 0; // Write pulses seen
  assign ad_i = bus_master_i ? mem_ad : host_ad;
  always #2.5 ref_clk_i = ~ref_clk_i;
  // The write byte only means something while the pulse stands
  always @(negedge ref_clk_i) begin
    if (wr_stb_o) begin
      wr_seen <= wr_byte_o;
      n_wr <= n_wr + 1;
    end
  end
  hbc_host_port DUT (.ref_clk_i, .arst_n_i, .chip_en_n_i, .data_strobe_n_i,
    .rd_wr_i, .rd_n_i, .wr_n_i, .addr_strobe_n_i, .section_select_pin_i,
    .channel_select_pin_i, .irq_ack_in_n_i, .prio_chain_in_i, .ad_i,
    .bus_master_i, .master_rd_i, .master_strobe_i, .dma_addr_lsb_i,
    .dev_byte_i, .src_req_i, .src_en_i, .src_is_dma_i, .master_irq_ctrl_i,
    .dma_irq_ctrl_i, .vector_base_i, .status_in_vec_i, .wait_rdy_i,
    .wait_rdy_o, .wait_rdy_oe_n_o, .ad_o, .ad_oe_n_o, .irq_n_o,
    .bus_config_word_o, .cfg_done_o, .mux_mode_o, .wait_style_o,
    .reg_addr_o, .wr_byte_o, .wr_stb_o, .dma_byte_o, .dma_byte_vld_o,
    .master_go_o);
  hbc_mem_model #(.WORD(MW)) u_mem (.ref_clk_i, .bus_master_i, .master_rd_i,
    .master_strobe_i, .wait_style_i(wait_style_o), .mem_ad_o(mem_ad),
    .wait_rdy_o(wait_rdy_i));
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // Slave cycle, strobe held four edges; ds picks strobe style
  task access(input logic wr, input logic [15:0] d, input logic ds);
    @(posedge ref_clk_i);
    chip_en_n_i <= 1'b0;
    host_ad <= d;
    rd_wr_i <= !wr;
    data_strobe_n_i <= !ds;
    rd_n_i <= ds || wr;
    wr_n_i <= ds || !wr;
    cyc(3);
    @(negedge ref_clk_i);
    snap = ad_o;
    snap_oe = ad_oe_n_o;
    snap_hs = {wait_rdy_oe_n_o, wait_rdy_o};
    @(posedge ref_clk_i);
    {chip_en_n_i, data_strobe_n_i, rd_n_i, wr_n_i} <= 4'hf;
    host_ad <= ~d;
    cyc(2);
    @(negedge ref_clk_i);
  endtask
  // Master transfer; reads wait for the byte under a bound
  task dma(input logic rd, input logic a0);
    int i;
    @(posedge ref_clk_i);
    {bus_master_i, master_rd_i, master_strobe_i} <= {1'b1, rd, 1'b1};
    dma_addr_lsb_i <= a0;
    for (i = 0; i < 8; i++) begin
      @(negedge ref_clk_i);
      if (rd ? dma_byte_vld_o === 1'b1 : i == 2) break;
    end
    snap = rd ? {8'h00, dma_byte_o} : ad_o;
    chk("go", 16'h0001, {15'h0, master_go_o});
    if (i == 8) begin
      chk("dma valid", 16'h0001, 16'h0000);
      end_sim;
    end else begin
      @(posedge ref_clk_i);
      {bus_master_i, master_strobe_i} <= 2'h0;
      cyc(1);
      @(negedge ref_clk_i);
    end
  endtask
  // Status-style vector: returned, then suppressed, then chain low
  task vec_test;
    @(posedge ref_clk_i);
    src_req_i <= 8'h0c;
    src_en_i <= 8'h08;
    cyc(3);
    @(negedge ref_clk_i);
    chk("irq", 16'h0000, {15'h0, irq_n_o});
    for (j = 0; j < 3; j++) begin
      @(posedge ref_clk_i);
      irq_ack_in_n_i <= 1'b0;
      master_irq_ctrl_i <= {6'h00, j == 1, 1'b0};
      dma_irq_ctrl_i <= {2'h0, j == 1, 5'h00};
      prio_chain_in_i <= j != 2;
      access(1'b0, 16'h0000, 1'b1);
      chk("vec oe", {15'h0, j != 0}, {15'h0, snap_oe});
      if (j == 0) chk("vec", 16'h00a3, {8'h00, snap[7:0]});
      @(posedge ref_clk_i);
      irq_ack_in_n_i <= 1'b1;
    end
    access(1'b0, 16'h0000, 1'b1);
    chk("read lanes", 16'h9696, snap);
    @(posedge ref_clk_i);
    src_en_i <= 8'h00;
    cyc(2);
    @(negedge ref_clk_i);
    chk("irq masked", 16'h0001, {15'h0, irq_n_o});
  endtask
  initial begin
    for (k = 0; k < 3; k++) begin
      @(posedge ref_clk_i);
      arst_n_i <= 1'b0;
      cyc(8);
      arst_n_i <= 1'b1;
      @(negedge ref_clk_i);
      chk("word rst", 16'h0000, {8'h00, bus_config_word_o});
      chk("done rst", 16'h0000, {15'h0, cfg_done_o});
      @(posedge ref_clk_i);
      channel_select_pin_i <= k[0];
      addr_strobe_n_i <= k != 2;
      host_ad <= 16'h002a;
      @(posedge ref_clk_i);
      addr_strobe_n_i <= 1'b1;
      access(1'b1, {8'hff, cfgs[k]}, k != 1);
      chk("word", {8'h00, cfgs[k]}, {8'h00, bus_config_word_o});
      chk("style", {15'h0, k[0]}, {15'h0, wait_style_o});
      chk("mux", {15'h0, k == 2}, {15'h0, mux_mode_o});
      chk("reg addr", k == 2 ? 16'h0015 : 16'h0000, {11'h0, reg_addr_o});
      access(1'b1, 16'hff55, 1'b1);
      chk("word kept", {8'h00, cfgs[k]}, {8'h00, bus_config_word_o});
      chk("wr byte", 16'h0055, {8'h00, wr_seen});
      chk("wr count", 16'(k + 1), 16'(n_wr));
      chk("slave hs", {14'h0, 1'b0, !k[0]}, {14'h0, snap_hs});
      for (j = 0; j < 2; j++) begin
        exp = (cfgs[k][7] && cfgs[k][6] == j[0]) ? MW[15:8] : MW[7:0];
        dma(1'b1, j[0]);
        chk("dma byte", {8'h00, exp}, snap);
      end
      dma(1'b0, 1'b0);
      chk("master wr", 16'h9696, snap);
      if (k == 0) vec_test;
      else begin
        // Pulsed styles: the acknowledge pin alone strobes the vector
        @(posedge ref_clk_i);
        {src_en_i, prio_chain_in_i, irq_ack_in_n_i} <= {8'h08, 2'b10};
        status_in_vec_i <= k == 1;
        cyc(2);
        @(negedge ref_clk_i);
        chk("pulse oe", 16'h0000, {15'h0, ad_oe_n_o});
        chk("pulse vec", k == 1 ? 16'ha3a3 : 16'ha0a0, ad_o);
        @(posedge ref_clk_i);
        {src_en_i, irq_ack_in_n_i} <= {8'h00, 1'b1};
      end
    end
    end_sim;
  end
endmodule
